// ---- mbce_pkg.sv ----
// Shared constants, opcode patterns and carrier types for the branch/compare/multiply execution unit
package mbce_pkg;

    localparam int PC_W = 16;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Execution lengths in clock cycles
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [2:0] CYC_RETURN = 3'h4;

    // Opcode masks and patterns
    localparam logic [15:0] M_HI6 = 16'hFC00;
    localparam logic [15:0] M_HI8 = 16'hFF00;
    localparam logic [15:0] M_HI4 = 16'hF000;
    localparam logic [15:0] M_ALL = 16'hFFFF;
    localparam logic [15:0] M_SET = 16'hFF0F;
    localparam logic [15:0] M_RBIT = 16'hFE08;
    localparam logic [15:0] M_LDST = 16'hFC0F;
    localparam logic [15:0] M_JMPCALL = 16'hFE0C;
    localparam logic [15:0] P_XOR = 16'h2400;
    localparam logic [15:0] P_SET = 16'hEF0F;
    localparam logic [15:0] P_MULU = 16'h9C00;
    localparam logic [15:0] P_MULTIPLY_SIGNED_OP = 16'h0200;
    localparam logic [15:0] P_MULGRP = 16'h0300;
    localparam logic [15:0] P_RJUMP = 16'hC000;
    localparam logic [15:0] P_RELATIVE_CALL_OP = 16'hD000;
    localparam logic [15:0] P_IJUMP = 16'h9409;
    localparam logic [15:0] P_INDIRECT_CALL_OP = 16'h9509;
    localparam logic [15:0] P_SRET = 16'h9508;
    localparam logic [15:0] P_IRET = 16'h9518;
    localparam logic [15:0] P_COMPARE_SKIP_EQUAL_OP = 16'h1000;
    localparam logic [15:0] P_CMP = 16'h1400;
    localparam logic [15:0] P_CMPC = 16'h0400;
    localparam logic [15:0] P_CMPI = 16'h3000;
    localparam logic [15:0] P_SRBC = 16'hFC00;
    localparam logic [15:0] P_SRBS = 16'hFE00;
    localparam logic [15:0] P_SIBC = 16'h9900;
    localparam logic [15:0] P_SIBS = 16'h9B00;
    localparam logic [15:0] P_BFS = 16'hF000;
    localparam logic [15:0] P_BFC = 16'hF400;
    localparam logic [15:0] P_LDST = 16'h9000;
    localparam logic [15:0] P_JMPCALL = 16'h940C;

    localparam logic [7:0] SET_VALUE = 8'hFF;
    localparam logic [4:0] UPPER_BANK = 5'h10;
    localparam logic [4:0] PAIR_BASE = 5'h00;

    typedef struct packed {
        logic [7:0] rdVal;
        logic [7:0] rrVal;
        logic [7:0] ioVal;
        logic [15:0] zPtr;
        logic [15:0] stackTop;
    } mbce_opnd_t;

    typedef struct packed {
        logic en;
        logic pair;
        logic [4:0] addr;
        logic [15:0] data;
    } mbce_wb_t;

    typedef enum logic [0:0] {
        ST_READY = 1'b0,
        ST_STALL = 1'b1
    } mbce_state_t;

endpackage : mbce_pkg

// ---- mbce_exec_unit.sv ----
// Execution unit for clear/set, multiplies, jumps, calls, returns, compares, skips and flag branches
`timescale 1ns/10ps

module mbce_exec_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [15:0] nextWord,
    input wire mbce_pkg::mbce_opnd_t operands,
    output logic instrReady_q,
    output logic [mbce_pkg::PC_W-1:0] pc_q,
    output logic [7:0] flags_q,
    output mbce_pkg::mbce_wb_t wrBack_q,
    output logic pushEn_q,
    output logic [mbce_pkg::PC_W-1:0] pushData_q,
    output logic popEn_q,
    output logic unknownOp_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire logic accept = instrValid && instrReady_q;
    wire logic [15:0] w = instrWord;
    wire logic [7:0] rd = operands.rdVal;
    wire logic [7:0] rr = operands.rrVal;
    wire logic [2:0] bitSel = w[2:0];

    wire logic isClr = ((w & mbce_pkg::M_HI6) == mbce_pkg::P_XOR) && (w[8:4] == {w[9], w[3:0]});
    wire logic isSet = (w & mbce_pkg::M_SET) == mbce_pkg::P_SET;
    wire logic isMulU = (w & mbce_pkg::M_HI6) == mbce_pkg::P_MULU;
    wire logic isMulS = (w & mbce_pkg::M_HI8) == mbce_pkg::P_MULTIPLY_SIGNED_OP;
    wire logic isMulGrp = (w & mbce_pkg::M_HI8) == mbce_pkg::P_MULGRP;
    wire logic isFrac = isMulGrp && (w[7] || w[3]);
    wire logic isMul = isMulU || isMulS || isMulGrp;
    wire logic isRJump = (w & mbce_pkg::M_HI4) == mbce_pkg::P_RJUMP;
    wire logic isRCall = (w & mbce_pkg::M_HI4) == mbce_pkg::P_RELATIVE_CALL_OP;
    wire logic isIJump = (w & mbce_pkg::M_ALL) == mbce_pkg::P_IJUMP;
    wire logic isICall = (w & mbce_pkg::M_ALL) == mbce_pkg::P_INDIRECT_CALL_OP;
    wire logic isSRet = (w & mbce_pkg::M_ALL) == mbce_pkg::P_SRET;
    wire logic isIRet = (w & mbce_pkg::M_ALL) == mbce_pkg::P_IRET;
    wire logic isCpse = (w & mbce_pkg::M_HI6) == mbce_pkg::P_COMPARE_SKIP_EQUAL_OP;
    wire logic isCmp = (w & mbce_pkg::M_HI6) == mbce_pkg::P_CMP;
    wire logic isCmpC = (w & mbce_pkg::M_HI6) == mbce_pkg::P_CMPC;
    wire logic isCmpI = (w & mbce_pkg::M_HI4) == mbce_pkg::P_CMPI;
    wire logic isSrbc = (w & mbce_pkg::M_RBIT) == mbce_pkg::P_SRBC;
    wire logic isSrbs = (w & mbce_pkg::M_RBIT) == mbce_pkg::P_SRBS;
    wire logic isSibc = (w & mbce_pkg::M_HI8) == mbce_pkg::P_SIBC;
    wire logic isSibs = (w & mbce_pkg::M_HI8) == mbce_pkg::P_SIBS;
    wire logic isBfs = (w & mbce_pkg::M_HI6) == mbce_pkg::P_BFS;
    wire logic isBfc = (w & mbce_pkg::M_HI6) == mbce_pkg::P_BFC;

    wire logic isCall = isRCall || isICall;
    wire logic isRet = isSRet || isIRet;
    wire logic isCompare = isCmp || isCmpC || isCmpI;
    wire logic isSkip = isCpse || isSrbc || isSrbs || isSibc || isSibs;
    wire logic isBranch = isBfs || isBfc;
    wire logic known = isClr || isSet || isMul || isRJump || isIJump || isCall || isRet
        || isCompare || isSkip || isBranch;

    // Skipping a two-word instruction costs one more word and one more cycle
    wire logic nextTwo = ((nextWord & mbce_pkg::M_LDST) == mbce_pkg::P_LDST)
        || ((nextWord & mbce_pkg::M_JMPCALL) == mbce_pkg::P_JMPCALL);

    ////////////////////////////////////////////////////////////////////////////
    // Program counter targets

    wire logic [mbce_pkg::PC_W-1:0] pcPlus1 = pc_q + 16'h0001;
    wire logic [mbce_pkg::PC_W-1:0] relOffset = {{4{w[11]}}, w[11:0]};
    wire logic [mbce_pkg::PC_W-1:0] brOffset = {{9{w[9]}}, w[9:3]};
    wire logic [mbce_pkg::PC_W-1:0] relTarget = pcPlus1 + relOffset;
    wire logic [mbce_pkg::PC_W-1:0] brTarget = pcPlus1 + brOffset;
    wire logic [mbce_pkg::PC_W-1:0] skipTarget = nextTwo ? pc_q + 16'h0003 : pc_q + 16'h0002;

    ////////////////////////////////////////////////////////////////////////////
    // Multiplier: sign-extend to nine bits so one signed product covers all variants

    wire logic signA = isMulS || (isMulGrp && !(w[7] == 1'b0 && w[3] == 1'b1));
    wire logic signB = isMulS || (isMulGrp && w[7] && !w[3]);
    wire logic signed [8:0] mulA = {signA & rd[7], rd};
    wire logic signed [8:0] mulB = {signB & rr[7], rr};
    wire logic signed [17:0] mulFull = mulA * mulB;
    wire logic [15:0] mulProd = mulFull[15:0];
    wire logic [15:0] mulRes = isFrac ? {mulProd[14:0], 1'b0} : mulProd;
    wire logic mulCarry = mulProd[15];
    wire logic mulZero = (mulRes == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Compare: subtract without write-back

    wire logic [7:0] cmpB = isCmpI ? {w[11:8], w[3:0]} : rr;
    wire logic cmpCin = isCmpC & flags_q[mbce_pkg::FLAG_C];
    wire logic [8:0] cmpDiff = {1'b0, rd} - {1'b0, cmpB} - {8'h00, cmpCin};
    wire logic [7:0] cmpRes = cmpDiff[7:0];
    wire logic cmpH = (!rd[3] & cmpB[3]) | (cmpB[3] & cmpRes[3]) | (cmpRes[3] & !rd[3]);
    wire logic cmpV = (rd[7] & !cmpB[7] & !cmpRes[7]) | (!rd[7] & cmpB[7] & cmpRes[7]);
    wire logic cmpN = cmpRes[7];
    // With carry, a zero result only keeps Z set so multi-byte compares chain
    wire logic cmpZ = (cmpRes == 8'h00) && (!isCmpC || flags_q[mbce_pkg::FLAG_Z]);

    ////////////////////////////////////////////////////////////////////////////
    // Skip and branch conditions

    wire logic regBit = rd[bitSel];
    wire logic ioBit = operands.ioVal[bitSel];
    wire logic skipTaken = (isCpse && rd == rr)
        || (isSrbc && !regBit) || (isSrbs && regBit)
        || (isSibc && !ioBit) || (isSibs && ioBit);

    // Named branches are the generic ones with a fixed flag index: Z equal, C carry/lower,
    // N sign, S signed order, H half carry, T transfer, V overflow
    wire logic selFlag = flags_q[bitSel];
    wire logic brTaken = (isBfs && selFlag) || (isBfc && !selFlag);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state computation for an accepted instruction

    logic [mbce_pkg::PC_W-1:0] pcNew;
    logic [7:0] flagsNew;
    mbce_pkg::mbce_wb_t wbNew;
    logic [2:0] cycles;
    logic pushNew;
    logic popNew;

    always_comb begin
        pcNew = pcPlus1;
        flagsNew = flags_q;
        wbNew = '0;
        cycles = {1'b0, mbce_pkg::CYC_ONE};
        pushNew = 1'b0;
        popNew = 1'b0;
        if (isClr) begin
            wbNew.en = 1'b1;
            wbNew.addr = w[8:4];
            wbNew.data = {8'h00, rd ^ rd};
            flagsNew[mbce_pkg::FLAG_Z] = 1'b1;
            flagsNew[mbce_pkg::FLAG_N] = 1'b0;
            flagsNew[mbce_pkg::FLAG_V] = 1'b0;
            flagsNew[mbce_pkg::FLAG_S] = 1'b0;
        end else if (isSet) begin
            wbNew.en = 1'b1;
            wbNew.addr = mbce_pkg::UPPER_BANK | {1'b0, w[7:4]};
            wbNew.data = {8'h00, mbce_pkg::SET_VALUE};
        end else if (isMul) begin
            wbNew.en = 1'b1;
            wbNew.pair = 1'b1;
            wbNew.addr = mbce_pkg::PAIR_BASE;
            wbNew.data = mulRes;
            flagsNew[mbce_pkg::FLAG_Z] = mulZero;
            flagsNew[mbce_pkg::FLAG_C] = mulCarry;
            cycles = {1'b0, mbce_pkg::CYC_TWO};
        end else if (isRJump || isIJump) begin
            pcNew = isRJump ? relTarget : operands.zPtr;
            cycles = {1'b0, mbce_pkg::CYC_TWO};
        end else if (isCall) begin
            pcNew = isRCall ? relTarget : operands.zPtr;
            pushNew = 1'b1;
            cycles = {1'b0, mbce_pkg::CYC_THREE};
        end else if (isRet) begin
            pcNew = operands.stackTop;
            popNew = 1'b1;
            cycles = mbce_pkg::CYC_RETURN;
            if (isIRet) begin
                flagsNew[mbce_pkg::FLAG_I] = 1'b1;
            end
        end else if (isCompare) begin
            flagsNew[mbce_pkg::FLAG_Z] = cmpZ;
            flagsNew[mbce_pkg::FLAG_N] = cmpN;
            flagsNew[mbce_pkg::FLAG_V] = cmpV;
            flagsNew[mbce_pkg::FLAG_S] = cmpN ^ cmpV;
            flagsNew[mbce_pkg::FLAG_C] = cmpDiff[8];
            flagsNew[mbce_pkg::FLAG_H] = cmpH;
        end else if (isSkip && skipTaken) begin
            pcNew = skipTarget;
            cycles = nextTwo ? {1'b0, mbce_pkg::CYC_THREE} : {1'b0, mbce_pkg::CYC_TWO};
        end else if (isBranch && brTaken) begin
            pcNew = brTarget;
            cycles = {1'b0, mbce_pkg::CYC_TWO};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: effects land at the accept edge, then the unit stalls for the rest

    mbce_pkg::mbce_state_t state_q;
    logic [2:0] wait_q;
    wire logic [2:0] waitLoad = cycles - 3'h1;
    wire logic [2:0] waitDec = wait_q - 3'h1;
    wire logic stallDone = (state_q == mbce_pkg::ST_STALL) && (wait_q == 3'h1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= mbce_pkg::ST_READY;
            wait_q <= 3'h0;
            instrReady_q <= 1'b1;
        end else begin
            case (state_q)
                mbce_pkg::ST_READY: begin
                    if (accept && waitLoad != 3'h0) begin
                        state_q <= mbce_pkg::ST_STALL;
                        wait_q <= waitLoad;
                        instrReady_q <= 1'b0;
                    end
                end
                mbce_pkg::ST_STALL: begin
                    wait_q <= waitDec;
                    if (stallDone) begin
                        state_q <= mbce_pkg::ST_READY;
                        instrReady_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= mbce_pkg::ST_READY;
                    instrReady_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= mbce_pkg::PC_RESET;
            flags_q <= mbce_pkg::FLAGS_RESET;
        end else if (accept) begin
            pc_q <= pcNew;
            flags_q <= flagsNew;
        end
    end

    // Strobes last one cycle; the return address is the word after the call
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrBack_q <= '0;
            pushEn_q <= 1'b0;
            pushData_q <= mbce_pkg::PC_RESET;
            popEn_q <= 1'b0;
            unknownOp_q <= 1'b0;
        end else begin
            wrBack_q <= accept ? wbNew : '0;
            pushEn_q <= accept && pushNew;
            pushData_q <= (accept && pushNew) ? pcPlus1 : pushData_q;
            popEn_q <= accept && popNew;
            unknownOp_q <= accept && !known;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_clear_result: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isClr |=> wrBack_q.en && wrBack_q.data == 16'h0000 && flags_q[mbce_pkg::FLAG_Z]
            && !flags_q[mbce_pkg::FLAG_N] && !flags_q[mbce_pkg::FLAG_V] && instrReady_q)
        else $error("clear did not zero the register and flags in one cycle");

    a_set_value: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isSet |=> wrBack_q.data[7:0] == 8'hFF && flags_q == $past(flags_q) && instrReady_q)
        else $error("set did not load all ones or changed a flag");

    a_mul_timing: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isMul && !isFrac |=> wrBack_q.pair && wrBack_q.data == $past(mulProd)
            && flags_q[mbce_pkg::FLAG_C] == wrBack_q.data[15] && !instrReady_q ##1 instrReady_q)
        else $error("integer multiply result, carry or length wrong");

    a_frac_shift: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isFrac |=> wrBack_q.data == {$past(mulProd[14:0]), 1'b0}
            && flags_q[mbce_pkg::FLAG_C] == $past(mulProd[15]) && !instrReady_q ##1 instrReady_q)
        else $error("fractional multiply not shifted or wrong length");

    a_jump_timing: assert property (@(posedge clk_sys) disable iff (rst)
        accept && (isRJump || isIJump) |=> pc_q == ($past(isRJump)
            ? $past(pc_q) + 16'h0001 + {{4{$past(w[11])}}, $past(w[11:0])} : $past(operands.zPtr))
            && flags_q == $past(flags_q)
            && !instrReady_q ##1 instrReady_q)
        else $error("jump target or two-cycle length wrong");

    a_call_push: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isCall |=> pushEn_q && pushData_q == $past(pcPlus1) && !instrReady_q
            ##1 !pushEn_q && !instrReady_q ##1 instrReady_q)
        else $error("call did not push return address or take three cycles");

    a_return_length: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isRet |=> popEn_q && pc_q == $past(operands.stackTop)
            && (flags_q[mbce_pkg::FLAG_I] || !$past(isIRet)) ##0 !instrReady_q [*3] ##1 instrReady_q)
        else $error("return did not restore counter in four cycles");

    a_skip_length: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isSkip && skipTaken && nextTwo |=> pc_q == $past(pc_q) + 16'h0003
            ##0 !instrReady_q [*2] ##1 instrReady_q)
        else $error("skip over a two-word instruction wrong");

    a_compare_nowrite: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isCompare |=> !wrBack_q.en && instrReady_q
            && flags_q[mbce_pkg::FLAG_S] == (flags_q[mbce_pkg::FLAG_N] ^ flags_q[mbce_pkg::FLAG_V]))
        else $error("compare wrote a register or left inconsistent flags");

    a_branch_taken: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isBranch && brTaken |=> pc_q == $past(brTarget) && !instrReady_q ##1 instrReady_q)
        else $error("taken branch target or length wrong");

    a_branch_fall: assert property (@(posedge clk_sys) disable iff (rst)
        accept && isBranch && !brTaken |=> pc_q == $past(pc_q) + 16'h0001 && instrReady_q)
        else $error("untaken branch did not fall through in one cycle");

endmodule : mbce_exec_unit

// ---- mbce_prog_mem.sv ----
// Program memory model that feeds instruction words to the execution unit
`timescale 1ns/10ps

module mbce_prog_mem (
    input wire logic clk_sys,
    input wire logic [15:0] pcIn,
    output logic [15:0] instrWord,
    output logic [15:0] nextWord
);
    logic [15:0] mem [256];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
        instrWord = 16'h0000;
        nextWord = 16'h0000;
    end

    // Words change off the core's sampling edge, so the fetch never races the accept
    always @(negedge clk_sys) begin
        instrWord <= mem[pcIn[7:0]];
        nextWord <= mem[8'(pcIn[7:0] + 8'h01)];
    end

    task automatic put(input logic [15:0] a, input logic [15:0] w);
        mem[a[7:0]] = w;
    endtask : put
endmodule : mbce_prog_mem

// ---- mbce_exec_unit_tb.sv ----
// Self-checking testbench for the execution unit
`timescale 1ns/10ps

module mbce_exec_unit_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instrValid = 1'b0;
    logic [15:0] instrWord;
    logic [15:0] nextWord;
    mbce_pkg::mbce_opnd_t operands = '0;
    logic instrReady_q;
    logic [15:0] pc_q;
    logic [7:0] flags_q;
    mbce_pkg::mbce_wb_t wrBack_q;
    logic pushEn_q;
    logic [15:0] pushData_q;
    logic popEn_q;
    logic unknownOp_q;
    int err_count = 0;
    int checks_done = 0;
    logic [15:0] pcStart;
    logic [7:0] flagsStart;

    always #5 clk_sys = ~clk_sys;

    mbce_exec_unit dut_u (.clk_sys(clk_sys), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
        .nextWord(nextWord), .operands(operands), .instrReady_q(instrReady_q), .pc_q(pc_q), .flags_q(flags_q),
        .wrBack_q(wrBack_q), .pushEn_q(pushEn_q), .pushData_q(pushData_q), .popEn_q(popEn_q),
        .unknownOp_q(unknownOp_q));

    mbce_prog_mem pm_u (.clk_sys(clk_sys), .pcIn(pc_q), .instrWord(instrWord), .nextWord(nextWord));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] wbView();
        return {wrBack_q.en, wrBack_q.pair, wrBack_q.addr, 1'b0, wrBack_q.data[7:0]};
    endfunction : wbView

    function automatic logic [7:0] cmpRef(input logic [7:0] f, input logic [7:0] a, input logic [7:0] b,
                                          input logic ci, input logic zk);
        logic [8:0] r;
        logic [4:0] lo;
        logic v;
        r = {1'b0, a} - {1'b0, b} - 9'(ci);
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci);
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        return {f[7:6], lo[4], r[7] ^ v, v, r[7], (r[7:0] == 8'h00) & (~zk | f[1]), r[8]};
    endfunction : cmpRef

    // Words go into memory 1 ns after the rising edge, 4 ns before the partner latches them on the falling edge
    task automatic issue(input logic [15:0] w, input logic [15:0] nw, input logic [7:0] rd, input logic [7:0] rr,
                         input logic [7:0] io);
        @(posedge clk_sys);
        #1;
        pm_u.put(pc_q, w);
        pm_u.put(pc_q + 16'h0001, nw);
        pcStart = pc_q;
        flagsStart = flags_q;
        @(negedge clk_sys);
        operands = '{rdVal: rd, rrVal: rr, ioVal: io, zPtr: 16'h0040, stackTop: 16'h0023};
        instrValid = 1'b1;
        @(negedge clk_sys);
    endtask : issue

    // Valid stays up through the stall, so every stall also proves the request is refused
    task automatic settle(input int n);
        int cnt;
        logic [15:0] pcHeld;
        cnt = 0;
        pcHeld = pc_q;
        while (instrReady_q !== 1'b1 && cnt < 8) begin
            cnt++;
            @(negedge clk_sys);
            chk("pc in stall", pcHeld, pc_q);
        end
        instrValid = 1'b0;
        chk("stall cycles", 16'(n - 1), 16'(cnt));
    endtask : settle

    task automatic flow(input logic [15:0] w, input logic [15:0] nw, input logic [7:0] rd, input logic [7:0] rr,
                        input logic [7:0] io, input logic rel, input logic [15:0] tgt, input logic [3:0] pl,
                        input int n);
        issue(w, nw, rd, rr, io);
        chk("pc", rel ? pcStart + tgt : tgt, pc_q);
        chk("pulses", 16'(pl), 16'({wrBack_q.en, pushEn_q, popEn_q, unknownOp_q}));
        chk("flags", 16'({flagsStart[7] | (w == 16'h9518), flagsStart[6:0]}), 16'(flags_q));
        settle(n);
    endtask : flow

    task automatic cmpCase(input logic [15:0] w, input logic [7:0] a, input logic [7:0] b, input logic [7:0] rr,
                           input logic zk);
        issue(w, 16'h0000, a, rr, 8'h00);
        chk("compare flags", 16'(cmpRef(flagsStart, a, b, zk & flagsStart[0], zk)), 16'(flags_q));
        chk("compare pulses", 16'h0000, 16'({wrBack_q.en, pushEn_q, popEn_q, unknownOp_q}));
        settle(1);
    endtask : cmpCase

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_compare;
        cmpCase(16'h1456, 8'h00, 8'h01, 8'h01, 1'b0);
        cmpCase(16'h0456, 8'h10, 8'h0F, 8'h0F, 1'b1);
        cmpCase(16'h1456, 8'h05, 8'h05, 8'h05, 1'b0);
        cmpCase(16'h0456, 8'h05, 8'h05, 8'h05, 1'b1);
        cmpCase(16'h3800, 8'h00, 8'h80, 8'h55, 1'b0);
    endtask : t_compare

    task automatic t_clearSet;
        issue(16'h2455, 16'h0000, 8'h9A, 8'h9A, 8'h00);
        chk("clear write", 16'h8A00, wbView());
        chk("clear flags", 16'((flagsStart & 8'hE1) | 8'h02), 16'(flags_q));
        settle(1);
        issue(16'hEF1F, 16'h0000, 8'h9A, 8'h00, 8'h00);
        chk("set write", 16'hA2FF, wbView());
        chk("set flags", 16'(flagsStart), 16'(flags_q));
        settle(1);
        flow(16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0001, 4'h1, 1);
    endtask : t_clearSet

    task automatic t_jumpCall;
        flow(16'hC005, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0006, 4'h0, 2);
        flow(16'hCFFD, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, 16'hFFFE, 4'h0, 2);
        flow(16'h9409, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0040, 4'h0, 2);
        flow(16'hD007, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, 16'h0008, 4'h4, 3);
        chk("return address", pcStart + 16'h0001, pushData_q);
        flow(16'h9509, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0040, 4'h4, 3);
        chk("return address", pcStart + 16'h0001, pushData_q);
        flow(16'h9508, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0023, 4'h2, 4);
        flow(16'h9518, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0023, 4'h2, 4);
    endtask : t_jumpCall

    task automatic t_multiply;
        logic [15:0] ops [7];
        logic [6:0] sa;
        logic [6:0] sb;
        logic [6:0] fr;
        logic [7:0] b;
        logic [15:0] p;
        logic [15:0] res;
        ops = '{16'h9F01, 16'h0201, 16'h0301, 16'h0309, 16'h0381, 16'h0389, 16'h9F01};
        sa = 7'b0110110;
        sb = 7'b0010010;
        fr = 7'b0111000;
        for (int i = 0; i < 7; i++) begin
            b = (i == 6) ? 8'h00 : 8'h03;
            p = $signed({{8{sa[i]}}, 8'hC0}) * $signed({{8{sb[i] & b[7]}}, b});
            res = fr[i] ? p << 1 : p;
            issue(ops[i], 16'h0000, 8'hC0, b, 8'h00);
            chk("product", res, wrBack_q.data);
            chk("product target", 16'hC000 | 16'(res[7:0]), wbView());
            chk("product flags", 16'({flagsStart[7:2], res == 16'h0000, p[15]}), 16'(flags_q));
            settle(2);
        end
    endtask : t_multiply

    task automatic t_skips;
        flow(16'h1056, 16'h9000, 8'h3C, 8'h3C, 8'h00, 1'b1, 16'h0003, 4'h0, 3);
        flow(16'h1056, 16'h0000, 8'h3C, 8'h3D, 8'h00, 1'b1, 16'h0001, 4'h0, 1);
        flow(16'h1056, 16'h0000, 8'h3C, 8'h3C, 8'h00, 1'b1, 16'h0002, 4'h0, 2);
        flow(16'hFC52, 16'h0000, 8'hFB, 8'h00, 8'h00, 1'b1, 16'h0002, 4'h0, 2);
        flow(16'hFE52, 16'h0000, 8'hFB, 8'h00, 8'h00, 1'b1, 16'h0001, 4'h0, 1);
        flow(16'hFE52, 16'h940E, 8'h04, 8'h00, 8'h00, 1'b1, 16'h0003, 4'h0, 3);
        flow(16'h9919, 16'h0000, 8'h00, 8'h00, 8'h02, 1'b1, 16'h0001, 4'h0, 1);
        flow(16'h9B19, 16'h9200, 8'h00, 8'h00, 8'h02, 1'b1, 16'h0003, 4'h0, 3);
        flow(16'h9919, 16'h0000, 8'h00, 8'h00, 8'hFD, 1'b1, 16'h0002, 4'h0, 2);
    endtask : t_skips

    // All sixteen flag branches, alternating forward and backward offsets
    task automatic t_branch;
        logic tk;
        logic [15:0] w;
        for (int i = 0; i < 16; i++) begin
            tk = ((i % 8) == 4) ? flags_q[2] ^ flags_q[3] : flags_q[i % 8];
            tk = tk ^ (i >= 8);
            w = 16'hF000 | 16'(i % 8) | ((i >= 8) ? 16'h0400 : 16'h0000) | ((i % 2) ? 16'h03E0 : 16'h0020);
            flow(w, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b1, tk ? ((i % 2) ? 16'hFFFD : 16'h0005) : 16'h0001,
                 4'h0, tk ? 2 : 1);
        end
    endtask : t_branch

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_compare();
        t_branch();
        t_clearSet();
        t_jumpCall();
        t_branch();
        cmpCase(16'h1456, 8'h00, 8'h01, 8'h01, 1'b0);
        t_branch();
        t_multiply();
        t_skips();
        print_verdict();
    end
endmodule : mbce_exec_unit_tb
